// ===== verilog/nibble_io_ports.sv
// four small i/o ports with alternate functions and reset filter
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "nibble_io_defs.svh"
module nibble_io_ports #(
    parameter int RESET_MIN_CYCLES = `RESET_MIN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire nibble_io_pkg::reg_req_t req,
    output logic [3:0] rdata,
    input wire logic reset_n_pin,
    input wire logic watchdog_reset,
    input wire logic overrun_event,
    input wire logic prom_mode,
    output logic system_reset,
    output logic overrun_alarm_out,
    input wire logic [3:0] port_b_in,
    output nibble_io_pkg::pin_drive_t port_b_pin,
    input wire logic [3:0] port_c_in,
    output nibble_io_pkg::pin_drive_t port_c_pin,
    input wire logic [3:0] port_d_in,
    output nibble_io_pkg::pin_drive_t port_d_pin,
    input wire logic [2:0] port_1a_in,
    output logic [2:0] port_1a_out,
    output logic [2:0] port_1a_oe,
    input wire logic ir_envelope,
    input wire logic timer_out,
    input wire logic serial_clk_out,
    input wire logic serial_data_out,
    output logic serial_data_in,
    output logic ir_tx_out,
    output logic [3:0] prom_mode_selects,
    output logic [7:0] prom_data_bus
);
    import nibble_io_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [3:0] alt_function_select;
    logic [3:0] port_d_bit_direction;
    logic [3:0] port_group_direction;
    logic [2:0] port_1a_data;
    logic [3:0] port_b_data;
    logic [3:0] port_c_data;
    logic [3:0] port_d_data;
    logic [7:0] carrier_div;
    logic ir_enable;
    logic soft_reset;

    // pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [14:0] pin_s1, pin_s2, pin_s3, pin_q;
    logic [14:0] pin_raw;
    logic reset_pin_s1, reset_pin_s2, reset_pin_s3, reset_pin_q;
    assign pin_raw = {port_1a_in, port_d_in, port_c_in, port_b_in};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= 15'h7fff;
            pin_s2 <= 15'h7fff;
            pin_s3 <= 15'h7fff;
            pin_q <= 15'h7fff;
            reset_pin_s1 <= 1'b1;
            reset_pin_s2 <= 1'b1;
            reset_pin_s3 <= 1'b1;
            reset_pin_q <= 1'b1;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
            reset_pin_s1 <= reset_pin_n_mux();
            reset_pin_s2 <= reset_pin_s1;
            reset_pin_s3 <= reset_pin_s2;
            if (reset_pin_s2 == reset_pin_s3) begin
                reset_pin_q <= reset_pin_s2;
            end
        end
    end

    function automatic logic reset_pin_n_mux();
        return reset_n_pin;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset pin filter: low must persist for the minimum time
    reset_state_t rst_state;
    logic [$clog2(RESET_MIN_CYCLES+1)-1:0] low_count;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_state <= rst_idle;
            low_count <= '0;
        end else begin
            case (rst_state)
                rst_idle: begin
                    low_count <= '0;
                    if (!reset_pin_q) begin
                        rst_state <= rst_count;
                    end
                end
                rst_count: begin
                    if (reset_pin_q) begin
                        rst_state <= rst_idle; // [R17]
                    end else if (low_count ==
                            ($bits(low_count))'(RESET_MIN_CYCLES - 2)) begin
                        rst_state <= rst_active; // [R17]
                    end else begin
                        low_count <= low_count + 1'b1;
                    end
                end
                rst_active: begin
                    if (reset_pin_q) begin
                        rst_state <= rst_idle;
                    end
                end
                default: rst_state <= rst_idle;
            endcase
        end
    end

    assign soft_reset = (rst_state == rst_active) || watchdog_reset;
    assign system_reset = soft_reset;

    // alarm held low for one cycle per event and while event persists
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overrun_alarm_out <= 1'b1;
        end else begin
            overrun_alarm_out <= ~(overrun_event | watchdog_reset); // [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes; data latches survive reset of direction [R21]
    logic wr_bank0, wr_bank1;
    assign wr_bank0 = req.wr && !req.bank;
    assign wr_bank1 = req.wr && req.bank;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            alt_function_select <= `REG_RESET;
            port_d_bit_direction <= `REG_RESET;
            port_group_direction <= `REG_RESET;
        end else if (soft_reset) begin
            alt_function_select <= `REG_RESET;
            port_d_bit_direction <= `REG_RESET; // [R6]
            port_group_direction <= `REG_RESET; // [R6]
        end else if (req.wr) begin
            case (req.addr)
                `ALT_SEL_ADDR: alt_function_select <= req.wdata; // [R7]
                `PORT_D_DIR_ADDR: port_d_bit_direction <= req.wdata; // [R8]
                `GROUP_DIR_ADDR: port_group_direction <= req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_b_data <= `REG_RESET;
            port_c_data <= `REG_RESET;
            port_d_data <= `REG_RESET;
            port_1a_data <= 3'h0;
        end else begin
            if (wr_bank0 && req.addr == `PORT_B_ADDR) begin
                port_b_data <= req.wdata; // [R2] [R21]
            end
            if (wr_bank0 && req.addr == `PORT_C_ADDR) begin
                port_c_data <= req.wdata; // [R5] [R21]
            end
            if (wr_bank0 && req.addr == `PORT_D_ADDR) begin
                port_d_data <= req.wdata; // [R9] [R21]
            end
            if (wr_bank1 && req.addr == `PORT_1A_ADDR) begin
                port_1a_data <= req.wdata[2:0]; // [R14] [R21]
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            carrier_div <= `CARRIER_DIV_RESET;
            ir_enable <= 1'b0;
        end else if (soft_reset) begin
            ir_enable <= 1'b0;
        end else if (wr_bank0 && req.addr == `CARRIER_DIV_ADDR) begin
            carrier_div <= {carrier_div[3:0], req.wdata};
        end else if (wr_bank0 && req.addr == `IR_CTRL_ADDR) begin
            ir_enable <= req.wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; inputs read pin, outputs latch
    logic [3:0] b_q, c_q, d_q;
    logic [2:0] a1_q;
    assign b_q = pin_q[3:0];
    assign c_q = pin_q[7:4];
    assign d_q = pin_q[11:8];
    assign a1_q = pin_q[14:12];
    logic b_out, c_out, a1_out;
    assign b_out = port_group_direction[`GDIR_B_BIT];
    assign c_out = port_group_direction[`GDIR_C_BIT];
    assign a1_out = port_group_direction[`GDIR_1A_BIT];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 4'h0;
        end else if (req.rd && !req.bank) begin
            case (req.addr)
                `ALT_SEL_ADDR: rdata <= alt_function_select;
                `PORT_D_DIR_ADDR: rdata <= port_d_bit_direction;
                `GROUP_DIR_ADDR: rdata <= port_group_direction;
                `PORT_B_ADDR: rdata <= b_out ? port_b_data : b_q; // [R2]
                `PORT_C_ADDR: rdata <= c_out ? port_c_data : c_q; // [R5]
                `PORT_D_ADDR: rdata <= (port_d_bit_direction & port_d_data)
                    | (~port_d_bit_direction & d_q); // [R9]
                `CARRIER_DIV_ADDR: rdata <= carrier_div[3:0];
                `IR_CTRL_ADDR: rdata <= {3'h0, ir_enable};
                default: rdata <= 4'h0;
            endcase
        end else if (req.rd && req.addr == `PORT_1A_ADDR) begin
            rdata <= {1'b0, a1_out ? port_1a_data : a1_q}; // [R14]
        end else if (req.rd) begin
            rdata <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drive; open-drain ports drive only low [R3]
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_b_pin <= '0;
            port_c_pin <= '0;
            port_d_pin <= '0;
            port_1a_out <= 3'h0;
            port_1a_oe <= 3'h0;
        end else if (prom_mode) begin
            port_b_pin <= '0; // [R19] [R20]
            port_c_pin <= '0; // [R19] [R20]
            port_d_pin <= '0;
            port_1a_out <= 3'h0;
            port_1a_oe <= 3'h0;
        end else begin
            port_b_pin.o <= 4'h0;
            port_b_pin.oe <= {4{b_out}} & ~port_b_data; // [R1] [R3]
            port_c_pin.o <= 4'h0;
            port_c_pin.oe <= {4{c_out}} & ~port_c_data; // [R4] [R3]
            port_d_pin.o[3:2] <= port_d_data[3:2];
            port_d_pin.oe[3:2] <= port_d_bit_direction[3:2]; // [R8]
            if (alt_function_select[`ALT_INDICATOR_BIT]) begin
                port_d_pin.o[0] <= ir_envelope; // [R10]
                port_d_pin.oe[0] <= 1'b1; // [R7]
            end else begin
                port_d_pin.o[0] <= port_d_data[0];
                port_d_pin.oe[0] <= port_d_bit_direction[0];
            end
            if (alt_function_select[`ALT_TIMER_BIT]) begin
                port_d_pin.o[1] <= timer_out; // [R11]
                port_d_pin.oe[1] <= 1'b1; // [R7]
            end else begin
                port_d_pin.o[1] <= port_d_data[1];
                port_d_pin.oe[1] <= port_d_bit_direction[1];
            end
            if (alt_function_select[`ALT_SERIAL_BIT]) begin
                port_1a_out <= {1'b0, serial_data_out, serial_clk_out};
                port_1a_oe <= 3'b011; // [R12] [R15]
            end else begin
                port_1a_out <= port_1a_data;
                port_1a_oe <= {3{a1_out}}; // [R13]
            end
        end
    end

    // serial input taken from the filtered pin 2 level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serial_data_in <= 1'b1;
        end else begin
            serial_data_in <= a1_q[2]; // [R15]
        end
    end

    // prom mode: ports B give mode selects, C the upper data nibble
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prom_mode_selects <= 4'h0;
            prom_data_bus <= 8'h00;
        end else if (prom_mode) begin
            prom_mode_selects <= b_q; // [R19]
            prom_data_bus <= {c_q, 4'h0}; // [R19]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // carrier: half period = (carrier_div+1) * 24 cycles at 50 MHz gives
    // about 1042 kHz down to 4 kHz; covers 16..1024 kHz [R16]
    logic [4:0] pre_count;
    logic [7:0] half_count;
    logic carrier;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_count <= 5'h0;
            half_count <= 8'h00;
            carrier <= 1'b0;
        end else if (pre_count == 5'h17) begin
            pre_count <= 5'h0;
            if (half_count == carrier_div) begin
                half_count <= 8'h00;
                carrier <= ~carrier; // [R16]
            end else begin
                half_count <= half_count + 8'h01;
            end
        end else begin
            pre_count <= pre_count + 5'h01;
        end
    end

    // envelope registered once so ir_tx_out and indicator align [R10]
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ir_tx_out <= 1'b0;
        end else begin
            ir_tx_out <= ir_enable & ir_envelope & carrier; // [R10] [R16]
        end
    end
endmodule

// ===== pkg/nibble_io_defs.svh
// register offsets, field positions, reset values and timing counts
//
// Behaviour
// (R1) port B pins switch together in/out by group direction bit 1.
// (R2) port B levels read, outputs written at bank 0 offset 71h.
// (R3) ports B and C only pull low or release; pull-ups give high.
// (R4) port C pins switch together in/out by group direction bit 2.
// (R5) port C levels read, outputs written at bank 0 offset 72h.
// (R6) reset pin or watchdog reset puts ports B, C, D, 1A in input mode.
// (R7) alt select 23h: bit 2 indicator on D0, bit 1 timer on D1.
// (R8) port D pins have own direction from 27h bits 3 to 0.
// (R9) port D levels read, outputs written at bank 0 offset 73h.
// (R10) indicator on D0 is NRZ IR envelope aligned with ir_tx_out.
// (R11) timer select puts 8-bit timer output on D1.
// (R12) 23h bit 0 turns port 1A into serial clock, out, in.
// (R13) port 1A pins switch together in/out by group direction bit 3.
// (R14) port 1A levels read, outputs written at bank 1 offset 70h.
// (R15) serial mode: clock pin 0, data out pin 1, data in pin 2.
// (R16) ir_tx_out carrier programmable from 16 kHz to 1024 kHz.
// (R17) reset pin must stay low at least 50 us before reset is taken.
// (R18) overrun alarm output driven low on watchdog expiry or overflow.
// (R19) PROM mode remaps osc input, ports A and C data, B mode selects; the code puts port C on data bits 7..4 and 0 on bits 3..0.
// (R20) PROM mode data bus and mode selects start as inputs.
// (R21) data written while pins are inputs is latched, driven later.
`ifndef NIBBLE_IO_DEFS_SVH
`define NIBBLE_IO_DEFS_SVH
`define ALT_SEL_ADDR 8'h23
`define PORT_D_DIR_ADDR 8'h27
`define GROUP_DIR_ADDR 8'h37
`define PORT_1A_ADDR 8'h70
`define PORT_B_ADDR 8'h71
`define PORT_C_ADDR 8'h72
`define PORT_D_ADDR 8'h73
`define CARRIER_DIV_ADDR 8'h74
`define IR_CTRL_ADDR 8'h75
`define ALT_SERIAL_BIT 0
`define ALT_TIMER_BIT 1
`define ALT_INDICATOR_BIT 2
`define GDIR_B_BIT 1
`define GDIR_C_BIT 2
`define GDIR_1A_BIT 3
`define REG_RESET 4'h0
`define CARRIER_DIV_RESET 8'h00
`define CLK_HZ 50000000
`define RESET_MIN_US 50
`define RESET_MIN_CYCLES ((`CLK_HZ / 1000000) * `RESET_MIN_US)
`endif

// ===== pkg/nibble_io_pkg.sv
// types shared by the nibble port block
package nibble_io_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic bank;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } pin_drive_t;
    typedef enum logic [2:0] {
        rst_idle = 3'b001,
        rst_count = 3'b010,
        rst_active = 3'b100
    } reset_state_t;
endpackage

// ===== testbench/nibble_io_checker_assertions.sv
// concurrent checks on the nibble port block pins
`timescale 1ns/1ps
module nibble_io_checker #(
    parameter int RESET_MIN_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire nibble_io_pkg::reg_req_t req,
    input wire logic [3:0] rdata,
    input wire logic reset_n_pin,
    input wire logic watchdog_reset,
    input wire logic overrun_event,
    input wire logic system_reset,
    input wire logic overrun_alarm_out,
    input wire nibble_io_pkg::pin_drive_t port_b_pin,
    input wire nibble_io_pkg::pin_drive_t port_c_pin,
    input wire nibble_io_pkg::pin_drive_t port_d_pin,
    input wire logic [2:0] port_1a_oe
);
    import nibble_io_pkg::*;
    int low_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // length of the current low stretch on the reset pin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= reset_n_pin ? 0 : low_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_b_no_high; port_b_pin.o == 4'h0; endproperty
    a_b_no_high: assert property (p_b_no_high)
        else $error("port b drives high");
    property p_c_no_high; port_c_pin.o == 4'h0; endproperty
    a_c_no_high: assert property (p_c_no_high)
        else $error("port c drives high");
    property p_reset_inputs;
        system_reset [*2] |=> port_b_pin.oe == 4'h0 && port_1a_oe == 3'h0
            && port_c_pin.oe == 4'h0 && port_d_pin.oe == 4'h0;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pins not inputs under reset");
    property p_alarm_evt; overrun_event |=> !overrun_alarm_out; endproperty
    a_alarm_evt: assert property (p_alarm_evt)
        else $error("alarm missed overrun");
    property p_alarm_wd; watchdog_reset |=> !overrun_alarm_out; endproperty
    a_alarm_wd: assert property (p_alarm_wd)
        else $error("alarm missed watchdog");
    property p_rdata_hold; !req.rd |=> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without read");
    property p_unmapped;
        req.rd && req.addr[7:4] == 4'h1 |=> rdata == 4'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_filter_min;
        $rose(system_reset) && !watchdog_reset |-> low_cnt >= RESET_MIN_CYCLES;
    endproperty
    a_filter_min: assert property (p_filter_min)
        else $error("reset taken from short pulse");
    property p_pin_high;
        (reset_n_pin && !watchdog_reset) [*6] |-> !system_reset;
    endproperty
    a_pin_high: assert property (p_pin_high)
        else $error("reset without cause");
endmodule
bind nibble_io_ports nibble_io_checker #(
    .RESET_MIN_CYCLES(RESET_MIN_CYCLES)
) nibble_io_checker_i (
    .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
    .reset_n_pin(reset_n_pin), .watchdog_reset(watchdog_reset),
    .overrun_event(overrun_event), .system_reset(system_reset),
    .overrun_alarm_out(overrun_alarm_out), .port_b_pin(port_b_pin),
    .port_c_pin(port_c_pin), .port_d_pin(port_d_pin),
    .port_1a_oe(port_1a_oe)
);

// ===== testbench/ext_pins.sv
// external circuitry on the port pins: pull-ups and outside drivers
`timescale 1ns/1ps
module ext_pins (
    input wire nibble_io_pkg::pin_drive_t port_b_pin,
    input wire nibble_io_pkg::pin_drive_t port_c_pin,
    input wire nibble_io_pkg::pin_drive_t port_d_pin,
    input wire logic [2:0] port_1a_out,
    input wire logic [2:0] port_1a_oe,
    input wire logic [3:0] ext_b,
    input wire logic [3:0] ext_c,
    input wire logic [3:0] ext_d,
    input wire logic [2:0] ext_1a,
    output logic [3:0] port_b_in,
    output logic [3:0] port_c_in,
    output logic [3:0] port_d_in,
    output logic [2:0] port_1a_in
);
    import nibble_io_pkg::*;
    // B and C wired-and: a low from either side wins, the pull-up gives high; D and 1A take the driven level
    assign port_b_in = ext_b & ~port_b_pin.oe;
    assign port_c_in = ext_c & ~port_c_pin.oe;
    assign port_d_in = (port_d_pin.o & port_d_pin.oe)
        | (ext_d & ~port_d_pin.oe);
    assign port_1a_in = (port_1a_out & port_1a_oe) | (ext_1a & ~port_1a_oe);
endmodule

// ===== testbench/tb.sv
// self-checking bench for the nibble port block
`timescale 1ns/1ps
module tb;
    import nibble_io_pkg::*;
    typedef struct {logic [7:0] a; logic b; logic [3:0] d, e;} row_t;
    logic ref_clk, rst, reset_n_pin, watchdog_reset, overrun_event;
    logic prom_mode, ir_envelope, timer_out, serial_clk_out;
    logic serial_data_out, system_reset, overrun_alarm_out;
    logic serial_data_in, ir_tx_out;
    reg_req_t req;
    logic [3:0] rdata, port_b_in, port_c_in, port_d_in, v;
    logic [3:0] ext_b, ext_c, ext_d, prom_mode_selects;
    logic [7:0] prom_data_bus;
    logic [2:0] port_1a_in, port_1a_out, port_1a_oe, ext_1a;
    pin_drive_t port_b_pin, port_c_pin, port_d_pin;
    int n_fail, checks_done, cyc, n;
    row_t rows[8] = '{'{8'h27, 0, 4'hf, 4'hf}, '{8'h23, 0, 4'h0, 4'h0},
        '{8'h71, 0, 4'h5, 4'hf}, '{8'h72, 0, 4'h9, 4'hf},
        '{8'h73, 0, 4'h6, 4'h6}, '{8'h70, 1, 4'h3, 4'h5},
        '{8'h37, 0, 4'he, 4'he}, '{8'h10, 0, 4'hf, 4'h0}};
    nibble_io_ports #(.RESET_MIN_CYCLES(20)) nibble_io_ports_i (
        .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
        .reset_n_pin(reset_n_pin), .watchdog_reset(watchdog_reset),
        .overrun_event(overrun_event), .prom_mode(prom_mode),
        .system_reset(system_reset), .overrun_alarm_out(overrun_alarm_out),
        .port_b_in(port_b_in), .port_b_pin(port_b_pin),
        .port_c_in(port_c_in), .port_c_pin(port_c_pin),
        .port_d_in(port_d_in), .port_d_pin(port_d_pin),
        .port_1a_in(port_1a_in), .port_1a_out(port_1a_out),
        .port_1a_oe(port_1a_oe), .ir_envelope(ir_envelope),
        .timer_out(timer_out), .serial_clk_out(serial_clk_out),
        .serial_data_out(serial_data_out), .serial_data_in(serial_data_in),
        .ir_tx_out(ir_tx_out), .prom_mode_selects(prom_mode_selects),
        .prom_data_bus(prom_data_bus));
    ext_pins ext_pins_i (.port_b_pin(port_b_pin), .port_c_pin(port_c_pin),
        .port_d_pin(port_d_pin), .port_1a_out(port_1a_out),
        .port_1a_oe(port_1a_oe), .ext_b(ext_b), .ext_c(ext_c),
        .ext_d(ext_d), .ext_1a(ext_1a), .port_b_in(port_b_in),
        .port_c_in(port_c_in), .port_d_in(port_d_in),
        .port_1a_in(port_1a_in));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic b, input logic [3:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, bank: b, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic b);
        @(posedge ref_clk);
        req <= '{addr: a, bank: b, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    // edges between two toggles of the carrier, bounded on both waits
    task automatic half(output int c);
        logic s;
        int k;
        tick(1);
        s = ir_tx_out;
        for (k = 0; k < 4000 && ir_tx_out === s; k++) tick(1);
        s = ir_tx_out;
        for (c = 0; c < 4000 && ir_tx_out === s; c++) tick(1);
    endtask
    task automatic oes(input string nm, input logic [14:0] e);
        chk(nm, {port_b_pin.oe, port_c_pin.oe, port_d_pin.oe, port_1a_oe}, e);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        rst = 1; req = '0; reset_n_pin = 1; watchdog_reset = 0;
        overrun_event = 0; prom_mode = 0; ir_envelope = 0; timer_out = 0;
        serial_clk_out = 0; serial_data_out = 0;
        ext_b = 4'hf; ext_c = 4'hf; ext_d = 4'ha; ext_1a = 3'h5;
        repeat (20) @(posedge ref_clk);
        rst <= 0;
        tick(1);
        chk("alarm idle", overrun_alarm_out, 1);
        oes("oe after reset", 0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].b, rows[i].d);
            rd(rows[i].a, rows[i].b);
            chk("readback", v, rows[i].e);
        end
        tick(3);
        oes("oe output", {4'ha, 4'h6, 4'hf, 3'h7});
        chk("d out", port_d_pin.o, 4'h6);
        chk("1a out", port_1a_out, 3'h3);
        chk("b c lows", {port_b_pin.o, port_c_pin.o}, 0);
        rd(8'h71, 0);
        chk("b latch", v, 4'h5);
        rd(8'h70, 1);
        chk("1a latch", v, 4'h3);
        wr(8'h27, 0, 4'h5);
        tick(5);
        chk("d bit dir", port_d_pin.oe, 4'h5);
        rd(8'h73, 0);
        chk("d mixed", v, 4'he);
        ir_envelope = 1;
        wr(8'h23, 0, 4'h6);
        tick(3);
        chk("alt d", {port_d_pin.oe[1:0], port_d_pin.o[1:0]}, 4'hd);
        ir_envelope = 0;
        timer_out = 1;
        tick(3);
        chk("alt d swap", port_d_pin.o[1:0], 2'h2);
        serial_clk_out = 1;
        ext_1a = 3'h4;
        wr(8'h23, 0, 4'h1);
        tick(6);
        chk("serial", {port_1a_oe, port_1a_out[1:0], serial_data_in}, 6'h1b);
        ext_1a = 3'h0;
        serial_data_out = 1;
        tick(6);
        chk("serial 2", {port_1a_out[1:0], serial_data_in}, 3'h6);
        wr(8'h74, 0, 4'h0);
        wr(8'h74, 0, 4'h0);
        wr(8'h75, 0, 4'h1);
        ir_envelope = 1;
        half(n);
        chk("carrier fast", n, 24);
        wr(8'h74, 0, 4'h3);
        wr(8'h74, 0, 4'hf);
        half(n);
        half(n);
        chk("carrier slow", n, 1536);
        overrun_event = 1;
        tick(1);
        overrun_event = 0;
        chk("alarm", overrun_alarm_out, 0);
        watchdog_reset = 1;
        tick(3);
        watchdog_reset = 0;
        tick(2);
        oes("oe watchdog", 0);
        wr(8'h37, 0, 4'he);
        reset_n_pin = 0;
        n = 0;
        repeat (15) begin tick(1); n += system_reset; end
        reset_n_pin = 1;
        tick(5);
        chk("short pulse", n, 0);
        reset_n_pin = 0;
        n = 0;
        repeat (30) begin tick(1); n += system_reset; end
        reset_n_pin = 1;
        chk("long pulse", n > 0, 1);
        tick(8);
        oes("oe pin reset", 0);
        wr(8'h37, 0, 4'he);
        ext_b = 4'h9;
        ext_c = 4'h6;
        prom_mode = 1;
        tick(8);
        chk("prom", {prom_mode_selects, prom_data_bus[7:4]}, 8'h96);
        oes("prom oe", 0);
        give_verdict();
    end
endmodule
